// ==== mq_map.svh ====
// register offsets, field positions, reset values and sizes of the queue block
`ifndef MQ_MAP_SVH
`define MQ_MAP_SVH
// ----------------------------------------
// queue geometry
// ----------------------------------------
`define MQ_NQ 32
`define MQ_QW 5
`define MQ_QB 16
`define MQ_PW 4
`define MQ_CW 5
`define MQ_GRP 8
`define MQ_AE_BYTES 5'h04
`define MQ_VOID_Q 5'h1F
`define MQ_ONE_B 5'h01
`define MQ_TWO_B 5'h02
`define MQ_CAP 5'h10
// ----------------------------------------
// address bus fields
// ----------------------------------------
`define MQ_ID_HI 7
`define MQ_ID_LO 5
`define MQ_Q_HI 4
`define MQ_GRP_HI 1
// ----------------------------------------
// apb register map
// ----------------------------------------
`define MQ_CTRL_OFS 12'h000
`define MQ_STAT_OFS 12'h004
`define MQ_QSEL_OFS 12'h008
`define MQ_QCOUNT_DEF 6'h20
`define MQ_CTRL_PKT 8
`define MQ_ZERO32 32'h00000000
`endif

// ==== mq_pkg.sv ====
// types shared by the multi-queue flag and width control block
package mq_pkg;
    // widths latched at master reset, one bit per port
    typedef struct packed {
        logic in9;   // write port is 9 bits
        logic out9;  // read port is 9 bits
    } width_cfg_t;
    // software control word
    typedef struct packed {
        logic pkt_mode;     // read port in packet mode
        logic [5:0] qcount; // queues in use, 32 is default mode
    } ctrl_t;
    // pending queue selection on either port
    typedef struct packed {
        logic vld;       // a selection waits to take hold
        logic dev;       // id bits matched this device
        logic [4:0] q;   // selected queue
    } qsel_t;
endpackage

// ==== mq_flag_ctrl.sv ====
// multi-queue port control: queue select, void queue, widths, flags
//
// Contract
// [RL1] strobe decode: id match, low two bits group
// [RL2] group picks queues shown on almost-empty lines
// [RL3] with under 32 queues, queue 31 is void
// [RL4] void queue reads empty, output held, valid off
// [RL5] void switch still drains previous queue pipeline
// [RL6] last word falls through when reads stop
// [RL7] default mode uses all 32 queues
// [RL8] controller never writes a queue used as void
// [RL9] void meaning only on the read port
// [RL10] void works in standard and packet mode
// [RL11] one word per read cycle, no bubbles
// [RL12] widths latched from select pins at reset
// [RL13] bytes packed little endian across widths
// [RL14] full counts in write width units
// [RL15] output valid counts in read width units
// [RL16] one width pair serves all queues
// [RL17] full flag shows only the write queue
// [RL18] full flag follows selection one edge later
// [RL19] full flag changes only on clock edges
// [RL20] read queue taken when read strobe high
// [RL21] low five bits queue, top three device
// [RL22] new read queue data two cycles later
// [RL23] width pins ignored after reset
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "mq_map.svh"

module mq_flag_ctrl (
    input wire logic sys_clk, // system clock
    input wire logic resetn, // master reset
    input wire logic [2:0] device_identity_pins, // static id
    input wire logic input_width_select, // 1 = 9 bit in
    input wire logic output_width_select, // 1 = 9 bit out
    input wire logic [7:0] write_queue_address_bus, // write select
    input wire logic write_address_strobe, // write select en
    input wire logic write_enable_n, // write strobe
    input wire logic [17:0] din, // write data
    input wire logic [7:0] read_queue_address_bus, // read select
    input wire logic read_address_strobe, // read select en
    input wire logic almost_empty_bus_strobe, // group select en
    input wire logic read_enable_n, // read strobe
    output logic [17:0] dout, // output register
    output logic output_valid_flag_n, // low = valid
    output logic output_valid_oe, // drives valid pin
    output logic active_queue_full_flag, // write queue full
    output logic active_queue_full_oe, // drives full pin
    output logic [7:0] almost_empty_flag_lines, // group status
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error
);

    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    logic [8:0] mem [`MQ_NQ*`MQ_QB]; // byte store, queue major
    logic [`MQ_CW-1:0] cnt_ff [`MQ_NQ]; // bytes held per queue
    logic [`MQ_PW-1:0] wp_ff [`MQ_NQ]; // write byte pointer
    logic [`MQ_PW-1:0] rp_ff [`MQ_NQ]; // read byte pointer
    logic [`MQ_NQ-1:0] full_q; // internal full per queue
    logic [`MQ_NQ-1:0] avail_q; // a read word is ready
    logic [`MQ_NQ-1:0] ae_q; // almost empty per queue
    logic [`MQ_NQ-1:0] void_q; // queue acts as void

    mq_pkg::width_cfg_t wcfg_ff; // latched bus widths
    mq_pkg::ctrl_t ctrl_ff; // software control
    mq_pkg::qsel_t wpend_ff; // write select in flight
    mq_pkg::qsel_t rpend_ff; // read select in flight
    logic [`MQ_QW-1:0] wq_ff; // active write queue
    logic wdev_ff; // this device owns writes
    logic [`MQ_QW-1:0] src_q_ff; // queue feeding the output
    logic rdev_ff; // this device owns reads
    logic [1:0] grp_ff; // almost-empty group
    logic [`MQ_CW-1:0] wb; // bytes per write
    logic [`MQ_CW-1:0] rb; // bytes per read
    logic wsel; // write select this edge
    logic rsel; // read select this edge
    logic ae_sel; // group select this edge
    logic wr_go; // a write is stored
    logic ld; // output register wants data
    logic rd_go; // a word leaves a queue
    logic [8:0] rbyte0; // low byte at read pointer
    logic [8:0] rbyte1; // next byte
    logic [`MQ_QW-1:0] full_q_sel; // queue the full flag tracks
    logic acc; // apb access phase
    logic [31:0] nxt_prdata; // read mux
    logic nxt_err; // unmapped address

    // ----------------------------------------
    // decode of the address buses
    // ----------------------------------------
    // device match on the top three bits, queue on the low five
    assign wsel = write_address_strobe & (write_queue_address_bus
        [`MQ_ID_HI:`MQ_ID_LO] == device_identity_pins); // [RL21]
    assign rsel = read_address_strobe; // [RL20]
    // group strobe only counts with the read strobe low
    assign ae_sel = ~read_address_strobe & almost_empty_bus_strobe
        & (read_queue_address_bus[`MQ_ID_HI:`MQ_ID_LO]
        == device_identity_pins); // [RL1]

    // ----------------------------------------
    // widths: latched at master reset only
    // ----------------------------------------
    // reset is synchronous, so the pins may be caught in its branch
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wcfg_ff.in9 <= input_width_select; // [RL12]
            wcfg_ff.out9 <= output_width_select; // [RL12]
        end
        // no else: pins are ignored until the next master reset
    end // [RL23]

    // both ports use one width for every queue
    assign wb = wcfg_ff.in9 ? `MQ_ONE_B : `MQ_TWO_B; // [RL16]
    assign rb = wcfg_ff.out9 ? `MQ_ONE_B : `MQ_TWO_B; // [RL16]

    // ----------------------------------------
    // per-queue accounting
    // ----------------------------------------
    // counting bytes lets each flag use its own port width
    genvar gi;
    generate
        for (gi = 0; gi < `MQ_NQ; gi = gi + 1) begin : g_q
            logic wr_hit; // this queue written now
            logic rd_hit; // this queue read now
            assign wr_hit = wr_go & (wq_ff == `MQ_QW'(gi));
            assign rd_hit = rd_go & (src_q_ff == `MQ_QW'(gi));
            // full when no room for one write-width unit
            assign full_q[gi] = cnt_ff[gi] > (`MQ_CAP - wb); // [RL14]
            // a word is ready once one read-width unit is held
            assign avail_q[gi] = cnt_ff[gi] >= rb; // [RL15]
            assign ae_q[gi] = cnt_ff[gi] <= `MQ_AE_BYTES;
            // queues past the count are void; count 32 leaves none
            assign void_q[gi] = `MQ_QW'(gi) >=
                ctrl_ff.qcount[`MQ_QW-1:0] & ~ctrl_ff.qcount[5]; // [RL3] [RL7]
            // counter and pointers move on every accepted transfer
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    cnt_ff[gi] <= '0;
                    wp_ff[gi] <= '0;
                    rp_ff[gi] <= '0;
                end else begin
                    cnt_ff[gi] <= cnt_ff[gi] + (wr_hit ? wb : '0)
                        - (rd_hit ? rb : '0);
                    if (wr_hit) begin
                        wp_ff[gi] <= wp_ff[gi] + wb[`MQ_PW-1:0];
                    end
                    if (rd_hit) begin
                        rp_ff[gi] <= rp_ff[gi] + rb[`MQ_PW-1:0];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // write queue selection and full flag
    // ----------------------------------------
    // selection takes hold one edge later, so the edge of selection
    // and the next one still write the previous queue
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wpend_ff <= '0;
            wq_ff <= '0;
            wdev_ff <= 1'b0;
        end else begin
            if (write_address_strobe) begin
                wpend_ff.vld <= 1'b1;
                wpend_ff.dev <= wsel;
                wpend_ff.q <= write_queue_address_bus[`MQ_Q_HI:0];
            end else begin
                wpend_ff.vld <= 1'b0;
            end
            if (wpend_ff.vld) begin
                wq_ff <= wpend_ff.q; // [RL18]
                wdev_ff <= wpend_ff.dev;
            end
        end
    end

    // the void address is an ordinary queue here
    assign wr_go = ~write_enable_n & wdev_ff & ~full_q[wq_ff]; // [RL9]

    // flag tracks the incoming queue as soon as it takes hold
    assign full_q_sel = wpend_ff.vld ? wpend_ff.q : wq_ff;

    // flag and enable are registered, so they move on edges only
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            active_queue_full_flag <= 1'b0;
            active_queue_full_oe <= 1'b0;
        end else begin
            active_queue_full_flag <= full_q[full_q_sel]; // [RL17] [RL19]
            active_queue_full_oe <= wpend_ff.vld ? wpend_ff.dev
                : wdev_ff;
        end
    end

    // ----------------------------------------
    // byte store: little endian packing
    // ----------------------------------------
    // low byte first; a 9 bit write stores only the low byte
    always_ff @(posedge sys_clk) begin
        if (wr_go) begin
            mem[{wq_ff, wp_ff[wq_ff]}] <= din[8:0]; // [RL13]
            if (!wcfg_ff.in9) begin
                mem[{wq_ff, wp_ff[wq_ff] + `MQ_PW'(1)}] <= din[17:9];
            end
        end
    end

    assign rbyte0 = mem[{src_q_ff, rp_ff[src_q_ff]}];
    assign rbyte1 = mem[{src_q_ff, rp_ff[src_q_ff] + `MQ_PW'(1)}];

    // ----------------------------------------
    // read queue selection
    // ----------------------------------------
    // the source changes one edge after selection, so the selecting
    // edge and the next still drain the old queue's pipeline
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rpend_ff <= '0;
            src_q_ff <= '0;
            rdev_ff <= 1'b0;
        end else begin
            if (rsel) begin
                rpend_ff.vld <= 1'b1;
                rpend_ff.dev <= read_queue_address_bus
                    [`MQ_ID_HI:`MQ_ID_LO] == device_identity_pins;
                rpend_ff.q <= read_queue_address_bus[`MQ_Q_HI:0];
            end else begin
                rpend_ff.vld <= 1'b0;
            end
            if (rpend_ff.vld) begin
                src_q_ff <= rpend_ff.q; // [RL22] [RL5]
                rdev_ff <= rpend_ff.dev;
            end
        end
    end

    // ----------------------------------------
    // output register and valid flag
    // ----------------------------------------
    // an invalid output pulls the next word without a read strobe
    assign ld = ~read_enable_n | output_valid_flag_n; // [RL6] [RL11]
    // void is empty in either read mode, packet bit not consulted
    assign rd_go = ld & rdev_ff & ~void_q[src_q_ff]
        & avail_q[src_q_ff]; // [RL4] [RL10]

    // one word per edge while data is there
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dout <= '0;
            output_valid_flag_n <= 1'b1;
        end else if (rd_go) begin
            dout <= wcfg_ff.out9 ? {9'h000, rbyte0}
                : {rbyte1, rbyte0}; // [RL13] [RL11]
            output_valid_flag_n <= 1'b0;
        end else if (ld) begin
            // empty or void: keep the old word, mark it stale
            output_valid_flag_n <= 1'b1; // [RL4]
        end
    end

    // valid pin driven only while this device owns the read port
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            output_valid_oe <= 1'b0;
        end else begin
            output_valid_oe <= rpend_ff.vld ? rpend_ff.dev : rdev_ff;
        end
    end

    // ----------------------------------------
    // almost-empty group bus
    // ----------------------------------------
    // group register is held until the next strobe
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            grp_ff <= 2'h0;
        end else if (ae_sel) begin
            grp_ff <= read_queue_address_bus[`MQ_GRP_HI:0]; // [RL1]
        end
    end

    // line i shows queue group*8+i
    generate
        for (gi = 0; gi < `MQ_GRP; gi = gi + 1) begin : g_ae
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    almost_empty_flag_lines[gi] <= 1'b1;
                end else begin
                    almost_empty_flag_lines[gi] <=
                        ae_q[{grp_ff, 3'(gi)}]; // [RL2]
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // no wait state: pready rises on the first access cycle
    assign acc = psel & penable & pready;

    always_comb begin
        nxt_prdata = `MQ_ZERO32;
        nxt_err = 1'b0;
        case (paddr)
            `MQ_CTRL_OFS: begin
                nxt_prdata[5:0] = ctrl_ff.qcount;
                nxt_prdata[`MQ_CTRL_PKT] = ctrl_ff.pkt_mode;
            end
            `MQ_STAT_OFS: begin
                nxt_prdata[0] = wcfg_ff.in9;
                nxt_prdata[1] = wcfg_ff.out9;
                nxt_prdata[2] = active_queue_full_flag;
                nxt_prdata[3] = output_valid_flag_n;
            end
            `MQ_QSEL_OFS: begin
                nxt_prdata[4:0] = src_q_ff;
                nxt_prdata[12:8] = wq_ff;
            end
            default: begin
                nxt_err = 1'b1;
            end
        endcase
    end

    // answer is registered in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= `MQ_ZERO32;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable & ~pready;
            if (psel & ~penable) begin
                prdata <= pwrite ? `MQ_ZERO32 : nxt_prdata;
                pslverr <= nxt_err;
            end
        end
    end

    // control write; only the queue count steers void decode
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_ff.qcount <= `MQ_QCOUNT_DEF; // [RL7]
            ctrl_ff.pkt_mode <= 1'b0;
        end else if (acc & pwrite & (paddr == `MQ_CTRL_OFS)) begin
            ctrl_ff.qcount <= pwdata[5:0];
            ctrl_ff.pkt_mode <= pwdata[`MQ_CTRL_PKT];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    grp_latch_a: assert property ( // [RL1]
        @(posedge sys_clk) disable iff (!resetn)
        ae_sel |=> grp_ff == $past(read_queue_address_bus[1:0]))
        else $error("group select not latched");

    ae_lines_a: assert property ( // [RL2]
        @(posedge sys_clk) disable iff (!resetn)
        $stable(grp_ff) |=> almost_empty_flag_lines
            == $past(ae_q[{grp_ff, 3'h0} +: 8]))
        else $error("almost-empty lines show wrong group");

    void_hold_a: assert property ( // [RL4]
        @(posedge sys_clk) disable iff (!resetn)
        (ld & void_q[src_q_ff]) |=> output_valid_flag_n & $stable(dout))
        else $error("void queue produced data");

    fall_through_a: assert property ( // [RL6]
        @(posedge sys_clk) disable iff (!resetn)
        (output_valid_flag_n & rdev_ff & ~void_q[src_q_ff]
            & avail_q[src_q_ff]) |=> !output_valid_flag_n)
        else $error("last word did not fall through");

    rd_switch_a: assert property ( // [RL22]
        @(posedge sys_clk) disable iff (!resetn)
        (rsel ##1 !rsel) |=> src_q_ff
            == $past(read_queue_address_bus[4:0], 2))
        else $error("read queue not in place after two cycles");

    wr_switch_a: assert property ( // [RL18]
        @(posedge sys_clk) disable iff (!resetn)
        write_address_strobe |=> ##1
            active_queue_full_flag == $past(full_q[wpend_ff.q]))
        else $error("full flag not following new write queue");

    width_keep_a: assert property ( // [RL23]
        @(posedge sys_clk) disable iff (!resetn)
        $past(resetn) |-> $stable(wcfg_ff))
        else $error("bus widths changed outside reset");

    no_overfill_a: assert property ( // [RL14]
        @(posedge sys_clk) disable iff (!resetn)
        wr_go |-> cnt_ff[wq_ff] + wb <= `MQ_CAP)
        else $error("write accepted into a full queue");

endmodule

// ==== ctl_model.sv ====
// system controller model driving the write and read queue ports
`timescale 1ns/10ps
module ctl_model #(
    parameter logic [2:0] DEV_ID = 3'h5 // bench id, value arbitrary
) (
    input wire logic sys_clk, // system clock
    output logic [7:0] write_queue_address_bus, // write select
    output logic write_address_strobe, // write select en
    output logic write_enable_n, // write strobe
    output logic [17:0] din, // write data
    output logic [7:0] read_queue_address_bus, // read select
    output logic read_address_strobe, // read select en
    output logic almost_empty_bus_strobe, // group select en
    output logic read_enable_n // read strobe
);
    // ----------------------------------------
    // idle levels at time zero
    // ----------------------------------------
    initial begin
        write_queue_address_bus = 8'h00;
        write_address_strobe = 1'b0;
        write_enable_n = 1'b1;
        din = 18'h00000;
        read_queue_address_bus = 8'h00;
        read_address_strobe = 1'b0;
        almost_empty_bus_strobe = 1'b0;
        read_enable_n = 1'b1;
    end

    // ----------------------------------------
    // port tasks
    // ----------------------------------------
    // one-edge selection; keep > 0 also reads across the switch
    task automatic sel(input logic rd, input logic [4:0] q, input int keep);
        @(posedge sys_clk);
        if (rd) begin
            read_queue_address_bus <= {DEV_ID, q};
            read_address_strobe <= 1'b1;
        end else begin
            write_queue_address_bus <= {DEV_ID, q};
            write_address_strobe <= 1'b1;
        end
        if (keep > 0) begin
            read_enable_n <= 1'b0;
        end
        @(posedge sys_clk);
        read_address_strobe <= 1'b0;
        write_address_strobe <= 1'b0;
        if (keep > 0) begin
            repeat (keep - 1) @(posedge sys_clk);
            read_enable_n <= 1'b1;
        end
    endtask

    // back-to-back writes; never aimed at a void or full queue
    task automatic put(input logic [17:0] d0, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            write_enable_n <= 1'b0;
            din <= d0 + 18'(i);
        end
        @(posedge sys_clk);
        write_enable_n <= 1'b1;
        din <= ~din;  // released bus must not show a stale word
    endtask

    // group select with don't-care bits 4 and 3 set on purpose
    task automatic grp(input logic [1:0] g);
        @(posedge sys_clk);
        read_queue_address_bus <= {DEV_ID, 2'b11, 1'b0, g};
        almost_empty_bus_strobe <= 1'b1;
        @(posedge sys_clk);
        almost_empty_bus_strobe <= 1'b0;
    endtask

    // n consecutive read edges
    task automatic pull(input int n);
        @(posedge sys_clk);
        read_enable_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        read_enable_n <= 1'b1;
    endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the multi-queue port control block
`timescale 1ns/10ps
`include "mq_map.svh"
module tb;
    localparam logic [2:0] DEV_ID = 3'h5; // arbitrary bench id
    logic sys_clk = 1'b0; // 100 MHz clock
    logic resetn = 1'b0; // master reset
    logic [2:0] device_identity_pins = DEV_ID; // static id
    logic input_width_select = 1'b0; // latched in reset
    logic output_width_select = 1'b0; // latched in reset
    logic psel = 1'b0; // apb select
    logic penable = 1'b0; // apb enable
    logic pwrite = 1'b0; // apb direction
    logic [11:0] paddr = 12'h000; // apb address
    logic [31:0] pwdata = 32'h00000000; // apb write data
    logic [7:0] write_queue_address_bus, read_queue_address_bus;
    logic write_address_strobe, write_enable_n, read_address_strobe;
    logic almost_empty_bus_strobe, read_enable_n;
    logic [17:0] din, dout;
    logic output_valid_flag_n, output_valid_oe;
    logic active_queue_full_flag, active_queue_full_oe;
    logic [7:0] almost_empty_flag_lines;
    logic [31:0] prdata;
    logic pready, pslverr;
    int miscompares = 0;
    int samples_checked = 0;

    always #5 sys_clk = ~sys_clk;

    mq_flag_ctrl DUT (
        .sys_clk, .resetn, .device_identity_pins, .input_width_select,
        .output_width_select, .write_queue_address_bus,
        .write_address_strobe, .write_enable_n, .din,
        .read_queue_address_bus, .read_address_strobe,
        .almost_empty_bus_strobe, .read_enable_n, .dout,
        .output_valid_flag_n, .output_valid_oe, .active_queue_full_flag,
        .active_queue_full_oe, .almost_empty_flag_lines, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr
    );
    ctl_model #(.DEV_ID(DEV_ID)) ctl (
        .sys_clk, .write_queue_address_bus, .write_address_strobe,
        .write_enable_n, .din, .read_queue_address_bus,
        .read_address_strobe, .almost_empty_bus_strobe, .read_enable_n
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // full flag against its expected level
    task automatic chf(input string nm, input logic e);
        chk(nm, 32'(active_queue_full_flag), 32'(e));
    endtask

    // wait n edges, then sample where outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rst(input logic iw, input logic ow);
        @(posedge sys_clk);
        resetn <= 1'b0;
        input_width_select <= iw;
        output_width_select <= ow;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask

    // apb transfer; waits on pready with a bound, no fixed latency
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // watchdog: whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        logic [31:0] rd;
        logic er;
        rst(1'b0, 1'b0);
        tick(0);
        chk("dout", 32'(dout), 32'h0);
        chk("ov_n", 32'(output_valid_flag_n), 32'h1);
        chk("full_oe", 32'(active_queue_full_oe), 32'h0);
        chk("ae_lines", 32'(almost_empty_flag_lines), 32'hFF);
        apb(1'b0, `MQ_CTRL_OFS, 32'h0, rd, er);
        chk("qcount", rd, 32'h20);
        apb(1'b0, `MQ_STAT_OFS, 32'h0, rd, er);
        chk("widths", rd & 32'h3, 32'h0);
        apb(1'b1, 12'h00C, 32'h5, rd, er);
        chk("unmapped_err", 32'(er), 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        // fill queue 3, then switch the write port away and back
        ctl.sel(1'b0, 5'd3, 0);
        tick(1);
        chk("full_oe", 32'(active_queue_full_oe), 32'h1);
        chf("full_new", 1'b0);
        ctl.put(18'h00100, 8);
        tick(2);
        chf("full_q3", 1'b1);
        ctl.sel(1'b0, 5'd4, 0);
        tick(1);
        chf("full_q4", 1'b0);
        ctl.sel(1'b0, 5'd3, 0);
        tick(0);
        chf("full_lag", 1'b0);
        tick(1);
        chf("full_back", 1'b1);
        // every group; only queue 3 holds more than the threshold
        for (int g = 0; g < 4; g++) begin
            ctl.grp(2'(g));
            tick(1);
            chk("ae_grp", 32'(almost_empty_flag_lines),
                (g == 0) ? 32'hF7 : 32'hFF);
        end
        apb(1'b1, `MQ_CTRL_OFS, 32'h1F, rd, er);
        ctl.sel(1'b0, 5'd31, 0);
        tick(1);
        chk("void_wr_oe", 32'(active_queue_full_oe), 32'h1);
        // read queue 3: fall through, then a run of reads
        ctl.sel(1'b1, 5'd3, 0);
        tick(2);
        chk("first", 32'(dout), 32'h100);
        chk("first_ov", 32'(output_valid_flag_n), 32'h0);
        chk("ov_oe", 32'(output_valid_oe), 32'h1);
        ctl.sel(1'b0, 5'd3, 0);
        tick(2);
        chf("full_rd", 1'b0);
        ctl.pull(3);
        tick(0);
        chk("run", 32'(dout), 32'h103);
        // switch to the void queue while reading on
        ctl.sel(1'b1, 5'd31, 3);
        tick(0);
        chk("void_hold", 32'(dout), 32'h105);
        chk("void_ov", 32'(output_valid_flag_n), 32'h1);
        ctl.sel(1'b1, 5'd3, 0);
        tick(2);
        chk("resume", 32'(dout), 32'h106);
        ctl.pull(1);
        tick(0);
        chk("last", 32'(dout), 32'h107);
        ctl.pull(1);
        tick(0);
        chk("last_hold", 32'(dout), 32'h107);
        chk("empty_ov", 32'(output_valid_flag_n), 32'h1);
        // 18 bit in, 9 bit out; pins moved after reset are ignored
        rst(1'b0, 1'b1);
        input_width_select <= 1'b1;
        output_width_select <= 1'b0;
        apb(1'b0, `MQ_STAT_OFS, 32'h0, rd, er);
        chk("widths", rd & 32'h3, 32'h2);
        ctl.sel(1'b0, 5'd2, 0);
        ctl.put(18'h34AC3, 8);
        tick(2);
        chf("full_w", 1'b1);
        ctl.sel(1'b1, 5'd2, 0);
        tick(2);
        chk("byte0", 32'(dout), 32'h0C3);
        tick(2);
        chf("full_1rd", 1'b1);
        ctl.pull(1);
        tick(0);
        chk("byte1", 32'(dout), 32'h1A5);
        tick(2);
        chf("full_2rd", 1'b0);
        final_report();
    end
endmodule
